// ---- core/isa_router_defs.svh ----
`ifndef ISA_ROUTER_DEFS_SVH
`define ISA_ROUTER_DEFS_SVH

// ****************************************
// Pin-sharing modes, field widths, counts and reset values
// ****************************************
`define MODE_PIN_SHARE_0  1'b0
`define MODE_PIN_SHARE_1  1'b1
`define IO_ADDR_W         16
`define MEM_ADDR_W        24
`define NUM_LDEV          5
`define NUM_IRQ_LINES     11
`define NUM_DMA_CH        5
`define IO_SIZE_W         3
`define IO_SIZE_MAX       3'h6
`define IRQ_SEL_W         4
`define IRQ_SEL_NONE      4'hF
`define DMA_SEL_W         3
`define DMA_SEL_NONE      3'h7
`define MEM_MASK_RESET    24'hFF0000
`define CSN_RESET         8'h00

`endif

// ---- core/isa_router_pkg.sv ----
package isa_router_pkg;

  // Plug-and-play card state; reset returns to waiting for the key.
  typedef enum logic [3:0] {
    ST_WAIT_KEY = 4'h1,
    ST_CONFIG   = 4'h2,
    ST_ACTIVE   = 4'h4,
    ST_SLEEP    = 4'h8
  } pnp_state_t;

endpackage

// ---- core/isa_card_resource_router.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "isa_router_defs.svh"

module isa_card_resource_router (
  input  wire logic                                      clk,
  input  wire logic                                      rst,
  input  wire logic                                      clk_en,
  // Configuration face; loaded from the serial store and the host.
  input  wire logic                                      cfg_mode,
  input  wire logic                                      cfg_key_seen,
  input  wire logic                                      cfg_wake,
  input  wire logic                                      cfg_activate,
  input  wire logic                                      cfg_exit,
  input  wire logic                                      cfg_defaults_loaded,
  input  wire logic                                      cfg_default_active,
  input  wire logic [7:0]                                cfg_csn_in,
  input  wire logic                                      cfg_csn_we,
  input  wire logic [`NUM_LDEV*`IO_ADDR_W-1:0]            cfg_io_base,
  input  wire logic [`NUM_LDEV*`IO_SIZE_W-1:0]            cfg_io_size,
  input  wire logic [2*`MEM_ADDR_W-1:0]                   cfg_mem_base,
  input  wire logic [2*`MEM_ADDR_W-1:0]                   cfg_mem_mask,
  input  wire logic [`NUM_LDEV*`IRQ_SEL_W-1:0]            cfg_irq_sel,
  input  wire logic [2*`DMA_SEL_W-1:0]                    cfg_dma_sel,
  input  wire logic [`NUM_LDEV-1:0]                       cfg_oen_a_dev,
  input  wire logic [`NUM_LDEV-1:0]                       cfg_oen_b_dev,
  output logic [7:0]                                     card_select_number,
  output logic                                           card_active,
  output logic                                           in_config,
  // Bus face.
  input  wire logic [15:0]                               bus_addr_lo,
  input  wire logic [2:0]                                shared_a16_18_in,
  input  wire logic [1:0]                                shared_a19_20_in,
  input  wire logic [1:0]                                shared_a21_22_in,
  output logic [1:0]                                     shared_a21_22_out,
  output logic [1:0]                                     shared_a21_22_oe,
  input  wire logic                                      shared_a23_in,
  output logic                                           shared_a23_out,
  output logic                                           shared_a23_oe,
  input  wire logic                                      shared_bale_in,
  output logic                                           shared_bale_out,
  output logic                                           shared_bale_oe,
  input  wire logic                                      bus_aen,
  input  wire logic                                      bus_ior_n,
  input  wire logic                                      bus_iow_n,
  input  wire logic                                      bus_memr_n,
  input  wire logic                                      bus_memw_n,
  input  wire logic [2:0]                                mapped_dma_ack_in_n,
  output logic [2:0]                                     mapped_dma_req_out,
  output logic [`NUM_IRQ_LINES-1:0]                      bus_irq,
  output logic                                           xcvr_output_enable_a_n,
  // Logical-device face.
  input  wire logic [1:0]                                dev_irq_in,
  input  wire logic [1:0]                                dev_dma_req_in,
  output logic [1:0]                                     dev_dma_ack_out_n,
  output logic [3:0]                                     dev_io_select_n,
  output logic [1:0]                                     dev_mem_select_n
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int SW = 16 + 3 + 2 + 2 + 1 + 1 + 5 + 3 + 2 + 2;

  // Idle bus levels, so that reset release shows no false strobe, latch pulse or request.
  localparam logic [SW-1:0] SYNC_IDLE = {
    16'h0000,
    3'h0,
    2'h3,
    2'h0,
    1'h0,
    1'h0,
    1'h1,
    4'hF,
    3'h7,
    2'h0,
    2'h0
  };

  logic [SW-1:0] raw, s1_r, s2_r;
  assign raw = {bus_addr_lo, shared_a16_18_in, shared_a19_20_in, shared_a21_22_in,
                shared_a23_in, shared_bale_in, bus_aen, bus_ior_n, bus_iow_n, bus_memr_n,
                bus_memw_n, mapped_dma_ack_in_n, dev_irq_in, dev_dma_req_in};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= SYNC_IDLE;
      s2_r <= SYNC_IDLE;
    end else if (clk_en) begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end

  logic [15:0] a_lo;
  logic [2:0]  a16_18;
  logic [1:0]  a19_20, a21_22, irq01, drq01;
  logic        a23, bale, aen, ior_n, iow_n, memr_n, memw_n;
  logic [2:0]  cdack_n;
  assign {a_lo, a16_18, a19_20, a21_22, a23, bale, aen, ior_n, iow_n, memr_n, memw_n,
          cdack_n, irq01, drq01} = s2_r;

  // ****************************************
  // Card state and upper address latch
  // ****************************************
  isa_router_pkg::pnp_state_t st_r, st_nxt;
  logic [7:0]  csn_r, csn_nxt;
  logic [7:0]  upper_r, upper_nxt;
  logic        bale_d_r, bale_d_nxt;

  always_comb begin
    st_nxt     = st_r;
    csn_nxt    = csn_r;
    upper_nxt  = upper_r;
    bale_d_nxt = bale;
    if (cfg_csn_we) begin
      csn_nxt = cfg_csn_in;
    end
    unique case (st_r)
      isa_router_pkg::ST_WAIT_KEY: begin
        if (cfg_defaults_loaded && cfg_default_active) begin
          st_nxt = isa_router_pkg::ST_ACTIVE;
        end else if (cfg_key_seen) begin
          st_nxt = isa_router_pkg::ST_SLEEP;
        end
      end
      isa_router_pkg::ST_SLEEP: begin
        if (cfg_wake) begin
          st_nxt = isa_router_pkg::ST_CONFIG;
        end
      end
      isa_router_pkg::ST_CONFIG: begin
        if (cfg_exit) begin
          st_nxt = cfg_activate ? isa_router_pkg::ST_ACTIVE : isa_router_pkg::ST_WAIT_KEY;
        end
      end
      isa_router_pkg::ST_ACTIVE: begin
        if (cfg_key_seen) begin
          st_nxt = isa_router_pkg::ST_SLEEP;
        end
      end
      default: st_nxt = isa_router_pkg::ST_WAIT_KEY;
    endcase
    // In mode 0, latch the upper address while address latch enable is high.
    if (cfg_mode == `MODE_PIN_SHARE_0 && bale) begin
      upper_nxt = {a23, a21_22, a19_20, a16_18};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r     <= isa_router_pkg::ST_WAIT_KEY;
      csn_r    <= `CSN_RESET;
      upper_r  <= 8'h00;
      bale_d_r <= 1'b0;
    end else if (clk_en) begin
      st_r     <= st_nxt;
      csn_r    <= csn_nxt;
      upper_r  <= upper_nxt;
      bale_d_r <= bale_d_nxt;
    end
  end

  // ****************************************
  // Decode and routing
  // ****************************************
  function automatic logic io_hit(input logic [15:0] a, input logic [15:0] base,
                                  input logic [2:0] size);
    logic [15:0] m;
    m = 16'hFFFF << ((size > `IO_SIZE_MAX) ? `IO_SIZE_MAX : size);
    io_hit = ((a & m) == (base & m));
  endfunction

  logic                      active, mode1;
  logic [23:0]               mem_addr;
  logic [`NUM_LDEV-1:0]      io_sel, rd_sel;
  logic [1:0]                mem_sel;
  logic [`NUM_LDEV-1:0]      irq_all;
  logic [`NUM_IRQ_LINES-1:0] irq_nxt;
  logic [`NUM_DMA_CH-1:0]    drq_ch, dack_ch;
  logic [1:0]                dack_nxt;

  assign active   = (st_r == isa_router_pkg::ST_ACTIVE);
  assign mode1    = (cfg_mode == `MODE_PIN_SHARE_1);
  assign mem_addr = {upper_r, a_lo};
  assign irq_all  = mode1 ? {a16_18, irq01} : {3'h0, irq01};
  assign dack_ch  = {mode1 ? ~a19_20 : 2'h0, ~cdack_n};

  genvar g;
  generate
    for (g = 0; g < `NUM_LDEV; g++) begin : g_io
      assign io_sel[g] = active && !aen && (!ior_n || !iow_n) && (mode1 || g < 2) &&
                         io_hit(a_lo, cfg_io_base[g*16 +: 16], cfg_io_size[g*3 +: 3]);
      assign rd_sel[g] = io_sel[g] && !ior_n;
    end
    for (g = 0; g < 2; g++) begin : g_mem
      assign mem_sel[g] = active && !mode1 && (!memr_n || !memw_n) &&
                          ((mem_addr & cfg_mem_mask[g*24 +: 24]) ==
                           (cfg_mem_base[g*24 +: 24] & cfg_mem_mask[g*24 +: 24]));
    end
  endgenerate

  always_comb begin
    irq_nxt  = '0;
    drq_ch   = '0;
    dack_nxt = 2'h0;
    for (int d = 0; d < `NUM_LDEV; d++) begin
      if (active && irq_all[d] && cfg_irq_sel[d*4 +: 4] < `NUM_IRQ_LINES) begin
        irq_nxt[cfg_irq_sel[d*4 +: 4]] = 1'b1;
      end
    end
    for (int d = 0; d < 2; d++) begin
      if (active && drq01[d] && cfg_dma_sel[d*3 +: 3] < (mode1 ? 3'h5 : 3'h3)) begin
        drq_ch[cfg_dma_sel[d*3 +: 3]] = 1'b1;
      end
      if (active && cfg_dma_sel[d*3 +: 3] < 3'h5) begin
        dack_nxt[d] = dack_ch[cfg_dma_sel[d*3 +: 3]];
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  logic [4:0]  io_r;
  logic [1:0]  mem_r, dack_r;
  logic [4:0]  drq_r;
  logic [10:0] irq_r;
  logic        oen_a_r, oen_b_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_r    <= '0;
      mem_r   <= '0;
      dack_r  <= '0;
      drq_r   <= '0;
      irq_r   <= '0;
      oen_a_r <= 1'b0;
      oen_b_r <= 1'b0;
    end else if (clk_en) begin
      io_r    <= io_sel;
      mem_r   <= mem_sel;
      dack_r  <= dack_nxt;
      drq_r   <= drq_ch;
      irq_r   <= irq_nxt;
      oen_a_r <= |(rd_sel & cfg_oen_a_dev);
      oen_b_r <= mode1 && |(rd_sel & cfg_oen_b_dev);
    end
  end

  // ****************************************
  // Output pins
  // ****************************************
  assign card_select_number     = csn_r;
  assign card_active            = active;
  assign in_config              = (st_r == isa_router_pkg::ST_CONFIG);
  assign bus_irq                = irq_r;
  assign mapped_dma_req_out     = drq_r[2:0];
  assign dev_dma_ack_out_n      = ~dack_r;
  assign dev_io_select_n        = ~{mode1 ? io_r[3:2] : 2'h0, io_r[1:0]};
  assign dev_mem_select_n       = ~mem_r;
  assign shared_a21_22_out      = drq_r[4:3];
  assign shared_a21_22_oe       = {2{mode1}};
  assign shared_a23_out         = ~io_r[4];
  assign shared_a23_oe          = mode1;
  assign shared_bale_out        = ~oen_b_r;
  assign shared_bale_oe         = mode1;
  assign xcvr_output_enable_a_n = ~oen_a_r;

endmodule

`default_nettype wire

// ---- testbench/isa_router_checker_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checks on the resource router
// ****************************************
module isa_router_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cfg_mode,
  input wire logic        bus_aen,
  input wire logic        bus_ior_n,
  input wire logic        bus_iow_n,
  input wire logic [7:0]  card_select_number,
  input wire logic        card_active,
  input wire logic [10:0] bus_irq,
  input wire logic [2:0]  mapped_dma_req_out,
  input wire logic [2:0]  mapped_dma_ack_in_n,
  input wire logic [3:0]  dev_io_select_n,
  input wire logic [1:0]  dev_mem_select_n,
  input wire logic [1:0]  shared_a19_20_in,
  input wire logic [1:0]  shared_a21_22_out,
  input wire logic [1:0]  shared_a21_22_oe,
  input wire logic        shared_a23_out,
  input wire logic        shared_a23_oe,
  input wire logic        shared_bale_oe,
  input wire logic [1:0]  dev_dma_req_in,
  input wire logic [1:0]  dev_dma_ack_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  reset_values_a: assert property (disable iff (1'b0) rst && $past(rst) |-> card_select_number == 8'h00 && !card_active)
    else $error("card state not cleared in reset");
  idle_routes_a: assert property ((!card_active)[*4] |-> bus_irq == 11'h000 && mapped_dma_req_out == 3'h0)
    else $error("routing while not active");
  aen_blocks_a: assert property (bus_aen |-> ##3 dev_io_select_n == 4'hF && (shared_a23_out || !shared_a23_oe))
    else $error("io select during address enable");
  no_strobe_a: assert property (bus_ior_n && bus_iow_n |-> ##3 dev_io_select_n == 4'hF)
    else $error("io select without strobe");
  mode0_pins_a: assert property ((!cfg_mode)[*4] |-> {shared_a21_22_oe, shared_a23_oe, shared_bale_oe} == 4'h0)
    else $error("shared pin driven in mode 0");
  mode1_pins_a: assert property (cfg_mode[*4] |-> {shared_a21_22_oe, shared_a23_oe, shared_bale_oe} == 4'hF)
    else $error("shared pin not driven in mode 1");
  mode1_nomem_a: assert property (cfg_mode[*4] |-> dev_mem_select_n == 2'h3)
    else $error("memory select in mode 1");
  dma_req_idle_a: assert property (dev_dma_req_in == 2'h0 |-> ##3 mapped_dma_req_out == 3'h0 && (shared_a21_22_out & shared_a21_22_oe) == 2'h0)
    else $error("bus request without device request");
  dma_ack_idle_a: assert property (mapped_dma_ack_in_n == 3'h7 && (shared_a19_20_in == 2'h3 || !cfg_mode) |-> ##3 dev_dma_ack_out_n == 2'h3)
    else $error("device ack without bus ack");
endmodule
`default_nettype wire

// ---- testbench/isa_dma_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bus DMA controller on the mapped channels
// ****************************************
module isa_dma_host (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic [4:0] req,
  output logic      [4:0] ack_n
);
  int unsigned cnt [5];
  // A channel grants one or six cycles after its request and drops the grant when the request goes.
  always @(posedge clk or posedge rst) begin
    for (int c = 0; c < 5; c++) begin
      if (rst) begin
        cnt[c] <= 0;
        ack_n[c] <= 1'b1;
      end else begin
        cnt[c] <= req[c] ? cnt[c] + 1 : 0;
        ack_n[c] <= !(req[c] && cnt[c] >= (slow ? 6 : 1));
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_isa_card_resource_router.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_isa_card_resource_router;
  logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, cfg_mode = 1'b0, slow, bale;
  logic cfg_key_seen, cfg_wake, cfg_activate, cfg_exit, cfg_defaults_loaded, cfg_default_active, cfg_csn_we;
  logic card_active, in_config, shared_a23_in, shared_a23_out, shared_a23_oe;
  logic shared_bale_in, shared_bale_out, shared_bale_oe, xcvr_output_enable_a_n;
  logic bus_aen, bus_ior_n, bus_iow_n, bus_memr_n, bus_memw_n;
  logic [7:0]   cfg_csn_in, card_select_number, a_hi;
  logic [79:0]  cfg_io_base;
  logic [14:0]  cfg_io_size;
  logic [47:0]  cfg_mem_base, cfg_mem_mask;
  logic [19:0]  cfg_irq_sel;
  logic [5:0]   cfg_dma_sel;
  logic [4:0]   cfg_oen_a_dev, cfg_oen_b_dev, req5, ack5_n;
  logic [15:0]  bus_addr_lo, seed = 16'h25EE, base, r;
  logic [2:0]   shared_a16_18_in, mapped_dma_ack_in_n, mapped_dma_req_out, irq_hi, sz;
  logic [1:0]   shared_a19_20_in, shared_a21_22_in, shared_a21_22_out, shared_a21_22_oe;
  logic [1:0]   dev_irq_in, dev_dma_req_in, dev_dma_ack_out_n, dev_mem_select_n;
  logic [3:0]   dev_io_select_n;
  logic [10:0]  bus_irq;
  logic [23:0]  a;
  int           errors = 0, n_tests = 0;
  assign shared_a16_18_in = cfg_mode ? irq_hi : a_hi[2:0];
  assign shared_a19_20_in = cfg_mode ? ack5_n[4:3] : a_hi[4:3];
  assign shared_a21_22_in = (shared_a21_22_oe & shared_a21_22_out) | (~shared_a21_22_oe & a_hi[6:5]);
  assign shared_a23_in = shared_a23_oe ? shared_a23_out : a_hi[7];
  assign shared_bale_in = shared_bale_oe ? shared_bale_out : bale;
  assign mapped_dma_ack_in_n = ack5_n[2:0];
  assign req5 = {shared_a21_22_out & shared_a21_22_oe, mapped_dma_req_out};
  isa_card_resource_router i_dut (.*);
  isa_dma_host i_host (.clk(clk), .rst(rst), .slow(slow), .req(req5), .ack_n(ack5_n));
  always #5 clk = ~clk;
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic cycle(logic [1:0] kind, logic aen, logic [15:0] lo);
    bus_addr_lo = lo;
    bus_aen = aen;
    bus_ior_n = kind != 2'h0;
    bus_iow_n = kind != 2'h1;
    bus_memr_n = kind != 2'h2;
    bus_memw_n = kind != 2'h3;
    tick(4);
  endtask
  task automatic idle();
    {bus_aen, bus_ior_n, bus_iow_n, bus_memr_n, bus_memw_n} = 5'h0F;
    tick(4);
  endtask
  task automatic do_reset(logic mode);
    rst = 1'b1;
    cfg_mode = mode;
    tick(20);
    chk("reset csn", 8'h00, card_select_number);
    chk("reset active", 1'b0, card_active);
    rst = 1'b0;
    tick();
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #50000;
    errors++;
    test_done();
  end
  initial begin
    {cfg_key_seen, cfg_wake, cfg_activate, cfg_exit, cfg_defaults_loaded, cfg_default_active, cfg_csn_we} = 7'h00;
    {cfg_csn_in, cfg_io_base, cfg_io_size, cfg_mem_base, cfg_dma_sel, a_hi, irq_hi} = '0;
    {cfg_mem_mask, cfg_irq_sel, cfg_oen_a_dev, cfg_oen_b_dev} = {48'hFF0000FF0000, 20'hFFFFF, 5'h01, 5'h10};
    {bus_aen, bus_ior_n, bus_iow_n, bus_memr_n, bus_memw_n, bus_addr_lo} = {5'h0F, 16'h0000};
    {dev_irq_in, dev_dma_req_in, bale, slow} = 6'h00;
    do_reset(1'b0);
    cfg_io_base[15:0] = 16'h0300;
    cycle(2'h0, 1'b0, 16'h0300);
    chk("select before active", 1'b1, dev_io_select_n[0]);
    idle();
    pulse(cfg_key_seen);
    pulse(cfg_wake);
    chk("in config", 1'b1, in_config);
    cfg_csn_in = 8'h5A;
    pulse(cfg_csn_we);
    chk("csn", 8'h5A, card_select_number);
    {cfg_activate, cfg_exit} = 2'h3;
    tick();
    {cfg_activate, cfg_exit} = 2'h0;
    tick();
    chk("active", 2'h2, {card_active, in_config});
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      sz = (i < 2) ? 3'h6 : r[2:0] % 7;
      base = rnd() & (16'hFFFF << sz);
      a[15:0] = (i < 2) ? base + 16'h003F + 16'(i) : base ^ {9'h000, r[15:9]};
      {cfg_io_base[15:0], cfg_io_size[2:0]} = {base, sz};
      tick();
      cycle({1'b0, r[12]}, r[11:10] == 2'h0, a[15:0]);
      chk("io select", !(r[11:10] != 2'h0 && (a[15:0] >> sz) == (base >> sz)), dev_io_select_n[0]);
      chk("xcvr enable", !(r[11:10] != 2'h0 && !r[12] && (a[15:0] >> sz) == (base >> sz)), xcvr_output_enable_a_n);
      idle();
    end
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      a = {r[7:0], rnd()};
      cfg_mem_base[23:0] = {(i % 2) ? a[23:16] : a[7:0], rnd()};
      {a_hi, bale} = {a[23:16], 1'b1};
      bus_addr_lo = a[15:0];
      tick(2);
      {a_hi, bale} = {~a[23:16], 1'b0};
      cycle({1'b1, i[0]}, 1'b0, a[15:0]);
      chk("mem select", a[23:16] != cfg_mem_base[23:16], dev_mem_select_n[0]);
      idle();
    end
    dev_irq_in = 2'h3;
    for (int i = 0; i < 12; i++) begin
      cfg_irq_sel[7:0] = {4'((i + 3) % 11), 4'(i)};
      tick(4);
      chk("irq lines", ((12'h001 << i) | (12'h001 << ((i + 3) % 11))) & 12'h7FF, bus_irq);
    end
    dev_irq_in = 2'h0;
    cfg_dma_sel[5:3] = 3'h7;
    for (int ch = 0; ch < 3; ch++) begin
      {cfg_dma_sel[2:0], slow, dev_dma_req_in} = {3'(ch), ch[0], 2'h1};
      tick(14);
      chk("bus request", 3'h1 << ch, mapped_dma_req_out);
      chk("device ack", 2'h2, dev_dma_ack_out_n);
      dev_dma_req_in = 2'h0;
      tick(12);
      chk("ack released", 2'h3, dev_dma_ack_out_n);
    end
    do_reset(1'b1);
    cfg_default_active = 1'b1;
    pulse(cfg_defaults_loaded);
    chk("default active", 1'b1, card_active);
    clk_en = 1'b0;
    pulse(cfg_key_seen);
    chk("frozen state", 1'b1, card_active);
    clk_en = 1'b1;
    {cfg_io_base[79:64], cfg_io_size[14:12]} = {16'h0220, 3'h2};
    for (int i = 0; i < 2; i++) begin
      cycle(2'h0, 1'b0, 16'h0223 + 16'(i));
      chk("dev4 select", i, shared_a23_out);
      chk("second enable", i, shared_bale_out);
      idle();
    end
    {cfg_irq_sel[11:8], irq_hi} = {4'h5, 3'h1};
    tick(4);
    chk("dev2 irq", 11'h020, bus_irq);
    {cfg_dma_sel[2:0], dev_dma_req_in} = {3'h3, 2'h1};
    tick(14);
    chk("ch3 request", 2'h1, shared_a21_22_out);
    chk("ch3 ack", 2'h2, dev_dma_ack_out_n);
    test_done();
  end
endmodule
bind isa_card_resource_router isa_router_checker i_chk (.*);
`default_nettype wire
